// file: rtl/crcu_defs.svh
`ifndef CRCU_DEFS_SVH
`define CRCU_DEFS_SVH

// APB address width and register byte offsets
`define CRCU_ADDR_W 12
`define CRCU_OFS_DATA 12'h000
`define CRCU_OFS_CTRL 12'h004
`define CRCU_OFS_INIT 12'h008
`define CRCU_OFS_GENERATOR_POLYNOMIAL 12'h00c

// Control register field positions
`define CRCU_CTRL_RESET 0
`define CRCU_CTRL_WSEL_LO 3
`define CRCU_CTRL_WSEL_HI 4
`define CRCU_CTRL_RIN_LO 5
`define CRCU_CTRL_RIN_HI 6
`define CRCU_CTRL_ROUT 7

// Reset values
`define CRCU_RST_CTRL 32'h0000_0000
`define CRCU_RST_INIT 32'hffff_ffff
`define CRCU_RST_GENERATOR_POLYNOMIAL 32'h04c1_1db7
`define CRCU_ZERO32 32'h0000_0000

// Byte-lane patterns accepted on the data register
`define CRCU_STRB_BYTE 4'h1
`define CRCU_STRB_HALF 4'h3
`define CRCU_STRB_WORD 4'hf

// Bit counts of data and generator widths
`define CRCU_NB_0 6'h00
`define CRCU_NB_1 6'h01
`define CRCU_NB_7 6'h07
`define CRCU_NB_8 6'h08
`define CRCU_NB_16 6'h10
`define CRCU_NB_32 6'h20

// Remainder masks per generator width
`define CRCU_MASK_32 32'hffff_ffff
`define CRCU_MASK_16 32'h0000_ffff
`define CRCU_MASK_8 32'h0000_00ff
`define CRCU_MASK_7 32'h0000_007f

`endif

// file: rtl/crcu_pkg.sv
package crcu_pkg;
  `include "crcu_defs.svh"

  // Generator width select, in field encoding order
  typedef enum logic [1:0] {CRCU_W32, CRCU_W16, CRCU_W8, CRCU_W7} crcu_width_t;
  // Input reversal granularity, in field encoding order
  typedef enum logic [1:0] {CRCU_REV_NONE, CRCU_REV_BYTE, CRCU_REV_HALF, CRCU_REV_WORD} crcu_rev_t;
  // Sequencer states
  typedef enum logic {CRCU_IDLE, CRCU_SHIFT} crcu_state_t;

  // Number of remainder bits for a width select
  function automatic logic [5:0] width_bits(input crcu_width_t w);
    case (w)
      CRCU_W16: width_bits = `CRCU_NB_16;
      CRCU_W8: width_bits = `CRCU_NB_8;
      CRCU_W7: width_bits = `CRCU_NB_7;
      default: width_bits = `CRCU_NB_32;
    endcase
  endfunction

  // Mask that keeps only the live remainder bits
  function automatic logic [31:0] width_mask(input crcu_width_t w);
    case (w)
      CRCU_W16: width_mask = `CRCU_MASK_16;
      CRCU_W8: width_mask = `CRCU_MASK_8;
      CRCU_W7: width_mask = `CRCU_MASK_7;
      default: width_mask = `CRCU_MASK_32;
    endcase
  endfunction
endpackage

// file: rtl/crcu_step.sv
`timescale 1ns/10ps
`include "crcu_defs.svh"

// One bit of polynomial division, MSB first
module crcu_step (
  input wire logic [31:0] crc_in,          // Current remainder
  input wire logic data_bit,               // Next message bit
  input wire logic [31:0] generator_polynomial,            // Generator coefficients
  input wire crcu_pkg::crcu_width_t wsel,  // Generator width select
  output logic [31:0] crc_out              // Remainder after the step
);

  logic [5:0] top_idx;
  logic feedback;
  logic [31:0] shifted;

  // Feeding the message bit into the top bit equals XORing the aligned word into the remainder up front
  always_comb begin
    top_idx = crcu_pkg::width_bits(wsel) - `CRCU_NB_1;
    feedback = crc_in[top_idx[4:0]] ^ data_bit;
    shifted = {crc_in[30:0], 1'b0};
    if (feedback) begin
      crc_out = (shifted ^ generator_polynomial) & crcu_pkg::width_mask(wsel);
    end else begin
      crc_out = shifted & crcu_pkg::width_mask(wsel);
    end
  end

endmodule

// file: rtl/crcu_top.sv
`timescale 1ns/10ps
`include "crcu_defs.svh"

// Summary of operation
// - A new word starts from the held remainder combined by XOR with the data.
// - Each step shifts left, XORing the generator when the top bit is one.
// - An 8-bit generator takes eight steps per byte; 0xC1/0xCB/0xFF gives 0x4C.
// - One 32-bit readable and writable data register serves as input and result.
// - Writing the data register feeds a word; reading returns the latest checksum.
// - Each data write folds into the held remainder, accumulating one checksum.
// - A programmable initial-value register supplies the starting remainder.
// - Control holds a two-bit input reversal field and an output reversal bit.
// - Control holds a two-bit generator width field; a register holds coefficients.
// - Writing the control reset bit loads the initial value into the data register.
// - Reset leaves control at zero and the initial value at all ones.
// - The width field selects generators of 7, 8, 16 or 32 bits.
// - Data writes of 8, 16 or 32 bits process only the bits written.
module crcu_top (
  input wire logic ref_clk,                   // System clock, 25 MHz
  input wire logic rst_b,                     // Synchronous reset, active low
  input wire logic psel,                      // APB select
  input wire logic penable,                   // APB access phase
  input wire logic pwrite,                    // APB write when high
  input wire logic [`CRCU_ADDR_W-1:0] paddr,  // APB byte address
  input wire logic [31:0] pwdata,             // APB write data
  input wire logic [3:0] pstrb,               // APB byte lane strobes
  output logic [31:0] prdata,                 // APB read data
  output logic pready,                        // APB transfer done
  output logic pslverr                        // APB error response
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Mirror all 32 bits
  function automatic logic [31:0] bit_rev32(input logic [31:0] d);
    logic [31:0] r;
    r = `CRCU_ZERO32;
    for (int i = 0; i < 32; i++) begin
      r[i] = d[31-i];
    end
    return r;
  endfunction

  // Written size in bits from the lane pattern, zero when unsupported
  // Only low-aligned byte, half-word and word writes are meaningful to the shifter
  function automatic logic [5:0] strb_bits(input logic [3:0] s);
    case (s)
      `CRCU_STRB_BYTE: strb_bits = `CRCU_NB_8;
      `CRCU_STRB_HALF: strb_bits = `CRCU_NB_16;
      `CRCU_STRB_WORD: strb_bits = `CRCU_NB_32;
      default: strb_bits = `CRCU_NB_0;
    endcase
  endfunction

  // Byte-lane merge for the configuration registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] s);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Input reversal; granularity is capped at the written size so no bits move out of the lane
  function automatic logic [31:0] rev_input(input logic [31:0] d, input crcu_pkg::crcu_rev_t mode,
                                             input logic [5:0] nb);
    logic [31:0] full;
    logic [31:0] r;
    full = bit_rev32(d);
    r = d;
    if (mode == crcu_pkg::CRCU_REV_BYTE || (mode != crcu_pkg::CRCU_REV_NONE && nb == `CRCU_NB_8)) begin
      r = {full[7:0], full[15:8], full[23:16], full[31:24]};
    end else if (mode == crcu_pkg::CRCU_REV_HALF || (mode == crcu_pkg::CRCU_REV_WORD && nb == `CRCU_NB_16)) begin
      r = {full[15:0], full[31:16]};
    end else if (mode == crcu_pkg::CRCU_REV_WORD) begin
      r = full;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and wires

  // Programmed state, sequencer and bus response
  crcu_pkg::crcu_width_t wsel_r;
  crcu_pkg::crcu_rev_t rin_r;
  logic rout_r;
  logic [31:0] init_r;
  logic [31:0] generator_polynomial_r;
  logic [31:0] data_r;
  logic [31:0] data_nxt;
  crcu_pkg::crcu_state_t state_r;
  logic [5:0] cnt_r;
  logic [31:0] sdata_r;
  logic ack_r;
  logic err_r;
  logic [31:0] prdata_r;

  // Bus decode and datapath nets
  logic access;
  logic idle;
  logic data_go;
  logic ctrl_go;
  logic restart;
  logic done_edge;
  logic wr_ok;
  logic [`CRCU_ADDR_W-1:0] word_addr;
  logic hit_data;
  logic hit_ctrl;
  logic hit_init;
  logic hit_generator_polynomial;
  logic hit_any;
  logic [5:0] wr_bits;
  logic [31:0] ctrl_view;
  logic [31:0] wr_word;
  logic [31:0] wr_aligned;
  logic [31:0] step_out;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Register map, one aligned word each, in byte addresses:
  //   000 checksum data, 004 checksum control, 008 initial value, 00c generator coefficients
  // Checksum control fields:
  //   bit 0 restart (reads zero), bits 4:3 generator width, bits 6:5 input reversal, bit 7 output mirror
  // Words outside the map answer with pslverr and read as zero

  // Low two address bits are ignored; each register is one aligned word
  assign word_addr = {paddr[`CRCU_ADDR_W-1:2], 2'b00};
  assign hit_data = (word_addr == `CRCU_OFS_DATA);
  assign hit_ctrl = (word_addr == `CRCU_OFS_CTRL);
  assign hit_init = (word_addr == `CRCU_OFS_INIT);
  assign hit_generator_polynomial = (word_addr == `CRCU_OFS_GENERATOR_POLYNOMIAL);
  assign hit_any = hit_data | hit_ctrl | hit_init | hit_generator_polynomial;
  assign wr_bits = strb_bits(pstrb);

  // Access phase, and the edge at which the transfer completes
  assign access = psel & penable;
  assign done_edge = access & ack_r;
  assign wr_ok = done_edge & pwrite & ~err_r;

  // Free to answer the bus only when the shifter has finished
  assign idle = (state_r == crcu_pkg::CRCU_IDLE);

  // Completed writes that start work; control only changes with its low byte lane
  assign data_go = wr_ok & hit_data;
  assign ctrl_go = wr_ok & hit_ctrl & pstrb[0];
  assign restart = ctrl_go & pwdata[`CRCU_CTRL_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake

  // Every access waits one registered cycle; no answer is given while shifting
  // Holding pready low is the only flow control, as there is no input buffer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else if (ack_r) begin
      ack_r <= 1'b0;
    end else if (access && idle) begin
      ack_r <= 1'b1;
    end
  end

  // Error for unmapped words and for data writes of an unsupported size
  // Configuration writes never fail; lanes left unstrobed are simply not written
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      err_r <= 1'b0;
    end else if (ack_r) begin
      err_r <= 1'b0;
    end else if (access && idle) begin
      err_r <= ~hit_any | (pwrite & hit_data & (wr_bits == `CRCU_NB_0));
    end
  end

  // Control register as software sees it; the reset bit always reads zero
  always_comb begin
    ctrl_view = `CRCU_RST_CTRL;
    ctrl_view[`CRCU_CTRL_WSEL_HI:`CRCU_CTRL_WSEL_LO] = wsel_r;
    ctrl_view[`CRCU_CTRL_RIN_HI:`CRCU_CTRL_RIN_LO] = rin_r;
    ctrl_view[`CRCU_CTRL_ROUT] = rout_r;
  end

  // Read data is captured from flip-flops on the same edge that raises pready
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata_r <= `CRCU_ZERO32;
    end else if (access && !ack_r && idle && !pwrite) begin
      if (hit_data) begin
        prdata_r <= rout_r ? bit_rev32(data_r) : data_r;
      end else if (hit_ctrl) begin
        prdata_r <= ctrl_view;
      end else if (hit_init) begin
        prdata_r <= init_r;
      end else if (hit_generator_polynomial) begin
        prdata_r <= generator_polynomial_r;
      end else begin
        prdata_r <= `CRCU_ZERO32;
      end
    end
  end

  // prdata and pready come straight from flip-flops; pslverr is ack_r ANDed with err_r
  assign prdata = prdata_r;
  assign pready = ack_r;
  assign pslverr = ack_r & err_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Width select, reversal options; a byte-0 write updates them
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wsel_r <= crcu_pkg::CRCU_W32;
      rin_r <= crcu_pkg::CRCU_REV_NONE;
      rout_r <= 1'b0;
    end else if (ctrl_go) begin
      wsel_r <= crcu_pkg::crcu_width_t'(pwdata[`CRCU_CTRL_WSEL_HI:`CRCU_CTRL_WSEL_LO]);
      rin_r <= crcu_pkg::crcu_rev_t'(pwdata[`CRCU_CTRL_RIN_HI:`CRCU_CTRL_RIN_LO]);
      rout_r <= pwdata[`CRCU_CTRL_ROUT];
    end
  end

  // Starting remainder for a new calculation
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      init_r <= `CRCU_RST_INIT;
    end else if (wr_ok && hit_init) begin
      init_r <= lane_merge(init_r, pwdata, pstrb);
    end
  end

  // Generator coefficients, implicit top term left out
  // The reset value is a common 32-bit generator, so an unprogrammed unit still gives a usable checksum
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      generator_polynomial_r <= `CRCU_RST_GENERATOR_POLYNOMIAL;
    end else if (wr_ok && hit_generator_polynomial) begin
      generator_polynomial_r <= lane_merge(generator_polynomial_r, pwdata, pstrb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data input path

  // Reverse, then left-align the written bits so the shifter takes the MSB first
  // A refused lane pattern never gets this far, since errored writes do not start the shifter
  always_comb begin
    wr_word = rev_input(pwdata, rin_r, wr_bits);
    case (wr_bits)
      `CRCU_NB_8: wr_aligned = {wr_word[7:0], 24'h00_0000};
      `CRCU_NB_16: wr_aligned = {wr_word[15:0], 16'h0000};
      default: wr_aligned = wr_word;
    endcase
  end

  // One division step per cycle
  // Width and coefficients cannot change mid-word, because the bus stalls while shifting
  crcu_step u_step (
    .crc_in(data_r),
    .data_bit(sdata_r[31]),
    .generator_polynomial(generator_polynomial_r),
    .wsel(wsel_r),
    .crc_out(step_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Bit-serial: a word costs 32 cycles, traded for a single XOR stage of logic
  // A data write can only land while idle, so no word is ever dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= crcu_pkg::CRCU_IDLE;
      cnt_r <= `CRCU_NB_0;
    end else begin
      case (state_r)
        crcu_pkg::CRCU_IDLE: begin
          if (data_go) begin
            state_r <= crcu_pkg::CRCU_SHIFT;
            cnt_r <= wr_bits - `CRCU_NB_1;
          end
        end
        crcu_pkg::CRCU_SHIFT: begin
          if (cnt_r == `CRCU_NB_0) begin
            state_r <= crcu_pkg::CRCU_IDLE;
          end else begin
            cnt_r <= cnt_r - `CRCU_NB_1;
          end
        end
        default: begin
          // Unreachable encodings fall back to idle
          state_r <= crcu_pkg::CRCU_IDLE;
          cnt_r <= `CRCU_NB_0;
        end
      endcase
    end
  end

  // Message shifter feeding one bit per cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sdata_r <= `CRCU_ZERO32;
    end else if (idle && data_go) begin
      sdata_r <= wr_aligned;
    end else if (state_r == crcu_pkg::CRCU_SHIFT) begin
      sdata_r <= {sdata_r[30:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remainder

  // The held remainder is never cleared by a data write, so words accumulate
  // Output mirroring lives on the read path only, so the held value stays unmirrored
  always_comb begin
    data_nxt = data_r;
    if (state_r == crcu_pkg::CRCU_SHIFT) begin
      data_nxt = step_out;
    end else if (restart) begin
      // A restart uses the width written in the same access, so one write resizes and reloads
      data_nxt = init_r & crcu_pkg::width_mask(
        crcu_pkg::crcu_width_t'(pwdata[`CRCU_CTRL_WSEL_HI:`CRCU_CTRL_WSEL_LO]));
    end
  end

  // Data register; after reset it already holds the default starting value
  // Bits above the generator width are cleared by the first step or by a restart
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      data_r <= `CRCU_RST_INIT;
    end else begin
      data_r <= data_nxt;
    end
  end

endmodule

// file: testbench/crcu_props.sv
`timescale 1ns/10ps
`include "crcu_defs.svh"
// Checks of the APB handshake and register responses
module crcu_props (
  input wire logic ref_clk,                   // Clock
  input wire logic rst_b,                     // Reset, active low
  input wire logic psel,                      // Select
  input wire logic penable,                   // Access phase
  input wire logic pwrite,                    // Write
  input wire logic [`CRCU_ADDR_W-1:0] paddr,  // Address
  input wire logic [31:0] pwdata,             // Write data
  input wire logic [3:0] pstrb,               // Strobes
  input wire logic [31:0] prdata,             // Read data
  input wire logic pready,                    // Done
  input wire logic pslverr                    // Error
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [9:0] wd;
  logic done, dat_b, bad_s;
  logic [4:0] ctl_m;
  // Word index and completion flags
  assign wd = paddr[`CRCU_ADDR_W-1:2];
  assign done = psel && penable && pready;
  assign bad_s = !(pstrb inside {`CRCU_STRB_BYTE, `CRCU_STRB_HALF, `CRCU_STRB_WORD});
  assign dat_b = done && pwrite && (wd == 10'h000) && (pstrb == `CRCU_STRB_BYTE) && !pslverr;
  // Control fields last written through the low lane; zero after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctl_m <= 5'h00;
    end else if (done && pwrite && wd == 10'h001 && pstrb[0] && !pslverr) begin
      ctl_m <= pwdata[`CRCU_CTRL_ROUT:`CRCU_CTRL_WSEL_LO];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_wait_state: assert property ($rose(penable) |-> !pready) else $error("no wait state");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_unmapped_err: assert property (done && wd > 10'h003 |-> pslverr) else $error("unmapped not refused");
  a_unmapped_zero: assert property (done && !pwrite && wd > 10'h003 |-> prdata == `CRCU_ZERO32)
    else $error("unmapped read not zero");
  a_bad_strobe: assert property (done && pwrite && wd == 10'h000 && bad_s |-> pslverr)
    else $error("bad strobe accepted");
  a_ctrl_spare: assert property (done && !pwrite && wd == 10'h001 |->
    prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0) else $error("control spare bits set");
  a_ctrl_echo: assert property (done && !pwrite && wd == 10'h001 |->
    prdata[`CRCU_CTRL_ROUT:`CRCU_CTRL_WSEL_LO] == ctl_m) else $error("control fields not as written");
  a_byte_stall: assert property (dat_b |=> !pready [*8]) else $error("bus answered while shifting");
  // Main scenarios are reached
  c_byte_write: cover property (dat_b);
  c_error: cover property (done && pslverr);
  c_data_read: cover property (done && !pwrite && wd == 10'h000);
endmodule

// file: testbench/crcu_apb_master.sv
`timescale 1ns/10ps
`include "crcu_defs.svh"
// APB master standing in for the processor or DMA
module crcu_apb_master (
  input wire logic ref_clk,                // Clock
  output logic psel,                       // Select
  output logic penable,                    // Access phase
  output logic pwrite,                     // Write
  output logic [`CRCU_ADDR_W-1:0] paddr,   // Address
  output logic [31:0] pwdata,              // Write data
  output logic [3:0] pstrb,                // Strobes
  input wire logic [31:0] prdata,          // Read data
  input wire logic pready,                 // Done
  input wire logic pslverr                 // Error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // One transfer; waits for pready as long as it takes, a hung slave is left to the bench watchdog
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data no longer shows the old word
    @(posedge ref_clk);
  endtask
endmodule

// file: testbench/crcu_top_tb.sv
`timescale 1ns/10ps
`include "crcu_defs.svh"
// Self-checking bench for the checksum unit
module crcu_top_tb;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [`CRCU_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rv, c, e, ctl;
  logic [3:0] pstrb;
  logic [31:0] dv [3] = '{32'h1234_5678, 32'h0000_beef, 32'h0000_005a};
  logic [3:0] sv [3] = '{4'hf, 4'h3, 4'h1};
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int w, nb, g;
  crcu_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  crcu_apb_master m (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////////
  // Reference division, MSB of the written part first
  function automatic logic [31:0] crc_ref(input logic [31:0] r, input logic [31:0] d, input int n,
                                          input int wb, input logic [31:0] p);
    logic fb;
    for (int i = n - 1; i >= 0; i--) begin
      fb = r[wb-1] ^ d[i];
      r = ((r << 1) ^ (fb ? p : 32'h0)) & 32'((64'h1 << wb) - 64'h1);
    end
    return r;
  endfunction
  // Mirror bits inside each chunk of gr bits; zero means untouched
  function automatic logic [31:0] input_bit_reverse(input logic [31:0] d, input int gr);
    logic [31:0] r;
    r = d;
    if (gr > 0) for (int i = 0; i < 32; i++) r[i] = d[(i / gr) * gr + gr - 1 - i % gr];
    return r;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic x);
    m.xfer(1'b1, a, d, s, rv, er);
    cmp({31'h0, er}, {31'h0, x});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic x);
    m.xfer(1'b0, a, 32'h0, 4'hf, rv, er);
    cmp(rv, exp);
    cmp({31'h0, er}, {31'h0, x});
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock and a watchdog far above the few hundred cycles needed
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 20000) begin
        miscompares++;
        $display("mismatch at %0t: run timed out", $time);
        give_verdict();
      end
    end
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(`CRCU_OFS_CTRL, `CRCU_RST_CTRL, 1'b0);
    rd(`CRCU_OFS_INIT, `CRCU_RST_INIT, 1'b0);
    rd(`CRCU_OFS_DATA, 32'hffff_ffff, 1'b0);
    wr(`CRCU_OFS_INIT, 32'h0000_00ff, 4'hf, 1'b0);
    wr(`CRCU_OFS_GENERATOR_POLYNOMIAL, 32'h0000_00cb, 4'hf, 1'b0);
    wr(`CRCU_OFS_CTRL, 32'h0000_0011, 4'hf, 1'b0);
    wr(`CRCU_OFS_DATA, 32'h0000_00c1, 4'h1, 1'b0);
    rd(`CRCU_OFS_DATA, 32'h0000_004c, 1'b0);
    rd(`CRCU_OFS_GENERATOR_POLYNOMIAL, 32'h0000_00cb, 1'b0);
    rd(`CRCU_OFS_INIT, 32'h0000_00ff, 1'b0);
    wr(`CRCU_OFS_INIT, 32'h89ab_cdef, 4'hf, 1'b0);
    wr(`CRCU_OFS_GENERATOR_POLYNOMIAL, 32'h04c1_1db7, 4'hf, 1'b0);
    // Each width paired with the input reversal of the same field encoding, output mirror on odd steps
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 32 : (k == 1) ? 16 : (k == 2) ? 8 : 7;
      ctl = 32'(k * 8 + k * 32 + (k % 2) * 128);
      wr(`CRCU_OFS_CTRL, ctl | 32'h1, 4'hf, 1'b0);
      c = 32'h89ab_cdef & 32'((64'h1 << w) - 64'h1);
      for (int j = 0; j < 3; j++) begin
        nb = 32 >> j;
        g = (k == 0) ? 0 : (8 << (k - 1));
        if (g > nb) g = nb;
        wr(`CRCU_OFS_DATA, dv[j], sv[j], 1'b0);
        c = crc_ref(c, input_bit_reverse(dv[j], g), nb, w, 32'h04c1_1db7);
      end
      e = c;
      if (k % 2 == 1) e = {<<{c}};
      rd(`CRCU_OFS_DATA, e, 1'b0);
      rd(`CRCU_OFS_CTRL, ctl, 1'b0);
    end
    // Lane strobes limit configuration writes; control ignores writes without its low lane
    wr(`CRCU_OFS_INIT, 32'h7654_3210, 4'h3, 1'b0);
    rd(`CRCU_OFS_INIT, 32'h89ab_3210, 1'b0);
    wr(`CRCU_OFS_CTRL, 32'h0000_ff01, 4'h2, 1'b0);
    rd(`CRCU_OFS_CTRL, ctl, 1'b0);
    // Refused accesses leave the checksum alone
    rd(12'h010, 32'h0, 1'b1);
    wr(`CRCU_OFS_DATA, 32'h0000_ff00, 4'h2, 1'b1);
    wr(12'h014, 32'h0000_0001, 4'hf, 1'b1);
    rd(`CRCU_OFS_DATA, e, 1'b0);
    give_verdict();
  end
endmodule
bind crcu_top crcu_props u_props (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
